// File: verilog/cfs_supervisor.sv
/*
  Converter fault supervisor: overcurrent, thermal, overvoltage and
  undervoltage supervision with command-coded registers.
  Assumes comparator levels from the analog stage, temperature and
  voltage samples from converters, and a simple byte command port.
*/
module cfs_supervisor
  import cfs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic REG_SUPPLY_OK,
  input wire logic CONV_ENABLE,
  input wire logic PWM_IN,
  input wire logic SOFTSTART_DONE,
  input wire logic RISE_TICK,
  input wire logic HS_PEAK_CMP,
  input wire logic LS_OC_CMP,
  input wire logic BG_TRIP_CMP,
  input wire logic FIXED_OV_CMP,
  input wire logic FAULT_RESET,
  input wire logic ALERT_MASK,
  input wire logic TEMP_VALID,
  input wire logic [15:0] TEMP_SAMPLE,
  input wire logic VOUT_VALID,
  input wire logic [15:0] VOUT_SAMPLE,
  input wire logic [15:0] FB_LEVEL,
  input wire logic [15:0] FB_NOMINAL,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [7:0] CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  output logic [15:0] CMD_RDATA,
  output logic CMD_ACK,
  output logic HS_GATE_EN,
  output logic LS_GATE_EN,
  output logic ALERT_N,
  output logic CONVERTING
);

  // ==========================================================
  // Comparator synchronisers.
  logic [4:0] sync1_q, sync2_q;
  wire logic [4:0] raw_cmp = {FIXED_OV_CMP, BG_TRIP_CMP, LS_OC_CMP,
                              HS_PEAK_CMP, PWM_IN};
  // Two flops per level; only the second stage is used below.
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= raw_cmp;
      sync2_q <= sync1_q;
    end
  end
  wire logic pwm_s = sync2_q[0];
  wire logic hs_s = sync2_q[1];
  wire logic ls_s = sync2_q[2];
  wire logic bg_s = sync2_q[3];
  wire logic fov_s = sync2_q[4];

  // ==========================================================
  // Registers reached by command code.
  logic [7:0] limits_q, resp_q, stat_temp_q, stat_misc_q;
  logic [15:0] ot_fault_q, ot_warn_q, ton_max_q, temp_q, vout_q;
  logic [15:0] cmd_rdata_q;
  logic cmd_ack_q;

  wire logic wr_ot_fault = CMD_WR && CMD_CODE == CFS_CMD_OT_FAULT;
  wire logic wr_ot_warn = CMD_WR && CMD_CODE == CFS_CMD_OT_WARN;
  wire logic wr_ton = CMD_WR && CMD_CODE == CFS_CMD_TON_MAX;
  wire logic wr_limits = CMD_WR && CMD_CODE == CFS_CMD_LIMITS;
  wire logic wr_resp = CMD_WR && CMD_CODE == CFS_CMD_RESP;
  wire logic clr_temp = CMD_WR && CMD_CODE == CFS_CMD_STAT_TEMP;
  wire logic clr_misc = CMD_WR && CMD_CODE == CFS_CMD_STAT_MISC;

  // Extracts a two-bit response field.
  function automatic logic [1:0] resp_of(input logic [7:0] r,
                                         input int pos);
    resp_of = r[pos +: 2];
  endfunction

  wire logic [1:0] ot_resp = resp_of(resp_q, CFS_RF_OT);
  wire logic [1:0] oc_resp = resp_of(resp_q, CFS_RF_OC);
  wire logic [1:0] ov_resp = resp_of(resp_q, CFS_RF_OV);
  wire logic [1:0] uv_resp = resp_of(resp_q, CFS_RF_UV);

  // Read mux; unknown codes read as zero.
  logic [15:0] rd_mux;
  always_comb begin
    unique case (CMD_CODE)
      CFS_CMD_OT_FAULT: rd_mux = ot_fault_q;
      CFS_CMD_OT_WARN: rd_mux = ot_warn_q;
      CFS_CMD_TON_MAX: rd_mux = ton_max_q;
      CFS_CMD_STAT_TEMP: rd_mux = {8'h00, stat_temp_q};
      CFS_CMD_READ_TEMP: rd_mux = temp_q;
      CFS_CMD_READ_VOUT: rd_mux = vout_q;
      CFS_CMD_LIMITS: rd_mux = {8'h00, limits_q};
      CFS_CMD_RESP: rd_mux = {8'h00, resp_q};
      CFS_CMD_STAT_MISC: rd_mux = {8'h00, stat_misc_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Writable configuration.
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ot_fault_q <= CFS_RST_OT_FAULT;
      ot_warn_q <= CFS_RST_OT_WARN;
      ton_max_q <= CFS_RST_TON_MAX;
      limits_q <= CFS_RST_LIMITS;
      resp_q <= CFS_RST_RESP;
    end else begin
      if (wr_ot_fault) ot_fault_q <= CMD_WDATA;
      if (wr_ot_warn) ot_warn_q <= CMD_WDATA;
      if (wr_ton) ton_max_q <= CMD_WDATA;
      if (wr_limits) limits_q <= CMD_WDATA[7:0];
      if (wr_resp) resp_q <= CMD_WDATA[7:0];
    end
  end

  // Read answer registered one cycle after the strobe.
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cmd_rdata_q <= 16'h0000;
      cmd_ack_q <= 1'b0;
    end else begin
      cmd_ack_q <= CMD_RD | CMD_WR;
      if (CMD_RD) cmd_rdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // Telemetry: temperature direct, output voltage averaged.
  wire logic [15:0] vout_avg = 16'(vout_q - (vout_q >> CFS_AVG_SHIFT)
                                   + (VOUT_SAMPLE >> CFS_AVG_SHIFT));
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      temp_q <= 16'h0000;
      vout_q <= 16'h0000;
    end else begin
      if (TEMP_VALID) temp_q <= TEMP_SAMPLE;
      if (VOUT_VALID) vout_q <= vout_avg;
    end
  end

  // ==========================================================
  // Thresholds. Limit select picks a preset step of one to four
  // thirty-seconds of nominal feedback, above it for OV, below for UV.
  function automatic logic [15:0] pct_of(input logic [15:0] nom,
                                         input logic [1:0] sel);
    logic [17:0] m;
    m = {2'b00, nom >> 5} * ({16'h0000, sel} + 18'h1);
    pct_of = m[15:0];
  endfunction
  wire logic [15:0] ov_lvl = 16'(FB_NOMINAL + pct_of(FB_NOMINAL,
                                 limits_q[1:0]));
  wire logic [15:0] uv_lvl = 16'(FB_NOMINAL - pct_of(FB_NOMINAL,
                                 limits_q[3:2]));
  // Overvoltage watched whenever the regulator supply is up.
  wire logic ov_det = REG_SUPPLY_OK &&
                      (FB_LEVEL > ov_lvl || fov_s);
  wire logic ot_fault_det = TEMP_VALID && TEMP_SAMPLE >= ot_fault_q;
  wire logic ot_warn_det = TEMP_VALID && TEMP_SAMPLE >= ot_warn_q;
  wire logic [15:0] cool_lvl = 16'(ot_fault_q - CFS_OT_HYST);

  // ==========================================================
  // Sequencer and counters.
  cfs_state_t st_q, st_d;
  logic [1:0] oc_cnt_q;
  logic pwm_prev_q, cyc_oc_q, bg_cool_q, ot_cool_q;
  logic [2:0] rise_cnt_q;
  logic [15:0] ms_cnt_q;
  logic [15:0] ms_tot_q;

  wire logic cyc_start = pwm_s && !pwm_prev_q;
  wire logic oc_now = (hs_s && pwm_s) || ls_s;
  wire logic oc_fault = cyc_start && cyc_oc_q && oc_cnt_q == 2'h2;
  wire logic ms_tick = ms_cnt_q == 16'(CFS_MS_CYC - 1);
  wire logic ton_expired = ms_tot_q >= ton_max_q;
  wire logic in_run = st_q == CFS_RUN;
  wire logic uv_armed = in_run && SOFTSTART_DONE && ton_expired;
  wire logic uv_det = uv_armed && FB_LEVEL < uv_lvl;
  wire logic ton_fault = st_q == CFS_START && ton_expired &&
                         FB_LEVEL < uv_lvl;
  wire logic ov_act = ov_det && ov_resp != CFS_RESP_IGNORE;
  wire logic oc_act = oc_fault && oc_resp != CFS_RESP_IGNORE;
  wire logic uv_act = (uv_det || ton_fault) &&
                      uv_resp != CFS_RESP_IGNORE;
  wire logic ot_act = ot_fault_det && ot_resp != CFS_RESP_IGNORE;
  wire logic active = st_q == CFS_START || in_run;

  // Counts consecutive overcurrent cycles; a clean cycle resets it.
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pwm_prev_q <= 1'b0;
      cyc_oc_q <= 1'b0;
      oc_cnt_q <= 2'h0;
    end else begin
      pwm_prev_q <= pwm_s;
      if (cyc_start) begin
        cyc_oc_q <= oc_now; // An event on the cycle edge is not lost.
        if (!cyc_oc_q) oc_cnt_q <= 2'h0;
        else if (oc_cnt_q == 2'h2) oc_cnt_q <= 2'h0;
        else oc_cnt_q <= 2'(oc_cnt_q + 2'h1);
      end else if (oc_now) begin
        cyc_oc_q <= 1'b1;
      end
    end
  end

  // Millisecond counter for the start-up limit; hiccup counts rises.
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || (st_q != CFS_START && st_q != CFS_RUN)) begin
      ms_cnt_q <= 16'h0000;
      ms_tot_q <= 16'h0000;
    end else begin
      ms_cnt_q <= ms_tick ? 16'h0000 : 16'(ms_cnt_q + 16'h1);
      if (ms_tick && !ton_expired) ms_tot_q <= 16'(ms_tot_q + 16'h1);
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || st_q != CFS_HICCUP) rise_cnt_q <= 3'h0;
    else if (RISE_TICK) rise_cnt_q <= 3'(rise_cnt_q + 3'h1);
  end

  // Cooling gates: bandgap trip releases when the comparator drops,
  // which carries the 20 degree hysteresis; programmable fault releases
  // 20 degrees below the fault threshold.
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      bg_cool_q <= 1'b0;
      ot_cool_q <= 1'b0;
    end else begin
      if (bg_s) bg_cool_q <= 1'b1;
      else if (st_q == CFS_COOL) bg_cool_q <= 1'b0;
      if (ot_act) ot_cool_q <= 1'b1;
      else if (TEMP_VALID && TEMP_SAMPLE <= cool_lvl) ot_cool_q <= 1'b0;
    end
  end

  // Next state; in CFS_START and CFS_RUN, bandgap trip outranks every programmable response.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      CFS_OFF: if (CONV_ENABLE) st_d = CFS_START;
      CFS_START, CFS_RUN: begin
        if (!CONV_ENABLE) st_d = CFS_OFF;
        else if (bg_s) st_d = CFS_COOL;
        else if (ov_act) st_d = CFS_DISCHARGE;
        else if (ot_act)
          st_d = ot_resp == CFS_RESP_LATCH ? CFS_LATCHED : CFS_COOL;
        else if (oc_act)
          st_d = oc_resp == CFS_RESP_LATCH ? CFS_LATCHED : CFS_HICCUP;
        else if (uv_act)
          st_d = uv_resp == CFS_RESP_LATCH ? CFS_LATCHED : CFS_HICCUP;
        else if (st_q == CFS_START && SOFTSTART_DONE) st_d = CFS_RUN;
      end
      CFS_DISCHARGE: if (!ov_det)
        st_d = ov_resp == CFS_RESP_LATCH ? CFS_LATCHED : CFS_HICCUP;
      CFS_HICCUP: if (rise_cnt_q == CFS_HICCUP_RISES) st_d = CFS_OFF;
      CFS_COOL: if (!bg_s && !bg_cool_q && !ot_cool_q) st_d = CFS_OFF;
      CFS_LATCHED: if (FAULT_RESET) st_d = CFS_OFF;
      default: st_d = CFS_OFF;
    endcase
  end
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) st_q <= CFS_OFF;
    else st_q <= st_d;
  end

  // ==========================================================
  // Status flags: hardware set wins over a same-cycle clear.
  // A write to a status code clears the bits written as one.
  wire logic [7:0] temp_set = {ot_fault_det, ot_warn_det, 6'h00};
  wire logic [7:0] misc_set = {3'h0, ton_fault, uv_det, ov_det,
                               oc_fault, bg_s};
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      stat_temp_q <= 8'h00;
      stat_misc_q <= 8'h00;
    end else begin
      stat_temp_q <= (stat_temp_q & ~(clr_temp ? CMD_WDATA[7:0] : 8'h00))
                     | temp_set;
      stat_misc_q <= (stat_misc_q & ~(clr_misc ? CMD_WDATA[7:0] : 8'h00))
                     | misc_set;
    end
  end

  // ==========================================================
  // Gate drive. A high-side trip kills the rest of the on period even
  // under ignore; the peak comparator bypasses the sync here because
  // two cycles of extra current is the hazard being prevented.
  logic hs_q, ls_q, alert_q;
  wire logic hs_kill = HS_PEAK_CMP || cyc_oc_q;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      hs_q <= active && pwm_s && !hs_kill && !ov_act;
      ls_q <= st_q == CFS_DISCHARGE || ov_act ||
              (active && !pwm_s);
      alert_q <= (|stat_temp_q || |stat_misc_q) && !ALERT_MASK;
    end
  end

  assign HS_GATE_EN = hs_q && !HS_PEAK_CMP;
  assign LS_GATE_EN = ls_q;
  assign ALERT_N = !alert_q;
  assign CONVERTING = active;
  assign CMD_RDATA = cmd_rdata_q;
  assign CMD_ACK = cmd_ack_q;

endmodule

// File: inc/cfs_pkg.sv
/*
  Constants for the converter fault supervisor: command codes, field
  positions, reset values and timing counts.
  Assumes a 40 MHz controller clock and a byte-wide command port that
  carries management-bus command codes.
*/
package cfs_pkg;

  // ==========================================================
  // Command codes of the management bus.
  localparam logic [7:0] CFS_CMD_OT_FAULT = 8'h4f;
  localparam logic [7:0] CFS_CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CFS_CMD_TON_MAX = 8'h62;
  localparam logic [7:0] CFS_CMD_STAT_TEMP = 8'h7d;
  localparam logic [7:0] CFS_CMD_READ_TEMP = 8'h8d;
  localparam logic [7:0] CFS_CMD_READ_VOUT = 8'h8b;
  localparam logic [7:0] CFS_CMD_LIMITS = 8'hd7;
  localparam logic [7:0] CFS_CMD_RESP = 8'he0;
  localparam logic [7:0] CFS_CMD_STAT_MISC = 8'he1;

  // ==========================================================
  // Thermal status bit positions.
  localparam int CFS_ST_OT_FAULT = 7;
  localparam int CFS_ST_OT_WARN = 6;

  // Miscellaneous status bit positions.
  localparam int CFS_SM_BG_OT = 0;
  localparam int CFS_SM_OC = 1;
  localparam int CFS_SM_OV = 2;
  localparam int CFS_SM_UV = 3;
  localparam int CFS_SM_TON_MAX = 4;

  // Response register fields: two bits each.
  localparam int CFS_RF_OT = 0;
  localparam int CFS_RF_OC = 2;
  localparam int CFS_RF_OV = 4;
  localparam int CFS_RF_UV = 6;

  // Response codes.
  localparam logic [1:0] CFS_RESP_IGNORE = 2'h0;
  localparam logic [1:0] CFS_RESP_LATCH = 2'h1;
  localparam logic [1:0] CFS_RESP_RESTART = 2'h2;

  // ==========================================================
  // Reset values: overtemperature response defaults to ignore.
  localparam logic [7:0] CFS_RST_RESP = 8'h28;
  localparam logic [7:0] CFS_RST_LIMITS = 8'h00;
  localparam logic [15:0] CFS_RST_OT_FAULT = 16'h007d;
  localparam logic [15:0] CFS_RST_OT_WARN = 16'h0073;
  localparam logic [15:0] CFS_RST_TON_MAX = 16'h0032;

  // ==========================================================
  // Timing and counts.
  localparam int CFS_CLK_HZ = 40_000_000;
  localparam int CFS_MS_TIME = 1;
  localparam int CFS_MS_CYC = CFS_CLK_HZ / 1000 * CFS_MS_TIME;
  localparam logic [1:0] CFS_OC_TRIP = 2'h3;
  localparam logic [2:0] CFS_HICCUP_RISES = 3'h7;
  localparam logic [15:0] CFS_OT_HYST = 16'h0014;
  localparam int CFS_AVG_SHIFT = 3;

  typedef enum logic [2:0] {
    CFS_OFF, CFS_START, CFS_RUN, CFS_DISCHARGE, CFS_HICCUP, CFS_COOL,
    CFS_LATCHED
  } cfs_state_t;

endpackage

// File: testbench/cfs_supervisor_properties.sv
/*
  Checker for the converter fault supervisor, bound to its top module.
  Assumes overvoltage is held four cycles or more only while its response
  is not ignore.
*/
module cfs_supervisor_checker (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic REG_SUPPLY_OK,
  input wire logic PWM_IN,
  input wire logic HS_PEAK_CMP,
  input wire logic BG_TRIP_CMP,
  input wire logic FIXED_OV_CMP,
  input wire logic ALERT_MASK,
  input wire logic CMD_WR,
  input wire logic CMD_RD,
  input wire logic [15:0] CMD_RDATA,
  input wire logic CMD_ACK,
  input wire logic HS_GATE_EN,
  input wire logic LS_GATE_EN,
  input wire logic ALERT_N,
  input wire logic CONVERTING
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // Trips must outlast the two-stage synchroniser before they count.
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence bg_held;
    BG_TRIP_CMP [*4];
  endsequence
  sequence ov_held;
    (FIXED_OV_CMP && REG_SUPPLY_OK) [*4];
  endsequence

  // ==========
  // Command port, gate and fault reactions.
  a_strobe_gets_ack: assert property ((CMD_WR || CMD_RD) |=> CMD_ACK)
    else $error("command strobe not acknowledged");
  a_ack_has_cause: assert property (
    CMD_ACK |-> ($past(CMD_WR) || $past(CMD_RD)))
    else $error("acknowledge without a strobe");
  a_rdata_holds: assert property (
    !$past(CMD_RD) |-> $stable(CMD_RDATA))
    else $error("read data changed without a read");
  a_peak_ends_cycle: assert property (HS_PEAK_CMP |-> !HS_GATE_EN)
    else $error("high-side gate on during a peak trip");
  a_gate_needs_pwm: assert property (HS_GATE_EN |-> $past(PWM_IN, 3))
    else $error("high-side gate on without a synchronised request");
  a_alert_not_masked: assert property (
    !ALERT_N |-> !$past(ALERT_MASK))
    else $error("alert raised while masked");
  a_ov_discharges: assert property (
    ov_held |-> ##[0:3] (LS_GATE_EN && !HS_GATE_EN))
    else $error("overvoltage did not turn the low side on");
  a_bg_stops_conv: assert property (
    bg_held |-> ##2 (!CONVERTING && !HS_GATE_EN))
    else $error("bandgap trip did not halt conversion");
endmodule

bind cfs_supervisor cfs_supervisor_checker u_cfs_supervisor_checker (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REG_SUPPLY_OK(REG_SUPPLY_OK),
  .PWM_IN(PWM_IN), .HS_PEAK_CMP(HS_PEAK_CMP), .BG_TRIP_CMP(BG_TRIP_CMP),
  .FIXED_OV_CMP(FIXED_OV_CMP), .ALERT_MASK(ALERT_MASK), .CMD_WR(CMD_WR),
  .CMD_RD(CMD_RD), .CMD_RDATA(CMD_RDATA), .CMD_ACK(CMD_ACK),
  .HS_GATE_EN(HS_GATE_EN), .LS_GATE_EN(LS_GATE_EN), .ALERT_N(ALERT_N),
  .CONVERTING(CONVERTING)
);

// File: testbench/cfs_host_model.sv
/*
  Behavioural management host issuing command-port reads and writes.
  Assumes strobes are taken on a rising edge and answered one edge later.
*/
module cfs_host_model (
  input wire logic ref_clk,
  input wire logic cmd_ack,
  input wire logic [15:0] cmd_rdata,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // The port idles with both strobes low.
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // One strobe per access; released lines show inverted, not stale, data.
  task automatic access(input logic wr, input logic [7:0] code,
    input logic [15:0] wdata, output logic [15:0] rdata, output logic ok);
    @(negedge ref_clk);
    cmd_wr = wr;
    cmd_rd = !wr;
    cmd_code = code;
    cmd_wdata = wdata;
    @(negedge ref_clk);
    ok = cmd_ack;
    rdata = cmd_rdata;
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~wdata;
  endtask
endmodule

// File: testbench/cfs_supervisor_bench.sv
/*
  Self-checking bench for the converter fault supervisor.
  Assumes the host model owns the command port; inputs move on falling edges.
*/
module cfs_supervisor_bench import cfs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========
  // Signals and the tables of register codes and values.
  logic ref_clk, sys_rst, supply_ok, conv_en, pwm, ss_done, rise_tick;
  logic hs_peak, ls_oc, bg_trip, fixed_ov, fault_rst, alert_mask;
  logic temp_valid, vout_valid, cmd_wr, cmd_rd, cmd_ack;
  logic hs_gate, ls_gate, alert_n, converting;
  logic [15:0] temp, vout, fb, fb_nom, cmd_wdata, cmd_rdata, rd_word;
  logic [7:0] cmd_code;
  int fail_count, samples_checked;
  localparam logic [7:0] RCODE [8] = '{8'h4f, 8'h51, 8'h62, 8'hd7,
    8'he0, 8'h7d, 8'he1, 8'h33};
  localparam logic [15:0] RVAL [8] = '{16'h007d, 16'h0073, 16'h0032,
    16'h0000, 16'h0028, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] WVAL [4] = '{16'h0070, 16'h0060, 16'h0001,
    16'hff05};

  cfs_supervisor u_cfs_supervisor (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .REG_SUPPLY_OK(supply_ok),
    .CONV_ENABLE(conv_en), .PWM_IN(pwm), .SOFTSTART_DONE(ss_done),
    .RISE_TICK(rise_tick), .HS_PEAK_CMP(hs_peak), .LS_OC_CMP(ls_oc),
    .BG_TRIP_CMP(bg_trip), .FIXED_OV_CMP(fixed_ov),
    .FAULT_RESET(fault_rst), .ALERT_MASK(alert_mask),
    .TEMP_VALID(temp_valid), .TEMP_SAMPLE(temp), .VOUT_VALID(vout_valid),
    .VOUT_SAMPLE(vout), .FB_LEVEL(fb), .FB_NOMINAL(fb_nom),
    .CMD_WR(cmd_wr), .CMD_RD(cmd_rd), .CMD_CODE(cmd_code),
    .CMD_WDATA(cmd_wdata), .CMD_RDATA(cmd_rdata), .CMD_ACK(cmd_ack),
    .HS_GATE_EN(hs_gate), .LS_GATE_EN(ls_gate), .ALERT_N(alert_n),
    .CONVERTING(converting)
  );
  cfs_host_model u_cfs_host_model (
    .ref_clk(ref_clk), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata)
  );

  // The 40 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // The run needs about 42000 cycles; a hang ends it as a failure.
  initial begin
    repeat (90000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end

  // ==========
  // Compare, bus and stimulus tasks.
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    fail_count += int'(got !== exp);
    if (got !== exp) $display("mismatch at %0t: %h not %h", $time, got, exp);
  endtask
  task automatic check_flag(input logic got, input logic exp);
    samples_checked++;
    fail_count += int'(got !== exp);
    if (got !== exp) $display("mismatch at %0t: flag %b", $time, got);
  endtask
  task automatic bus(input logic wr, input logic [7:0] code,
    input logic [15:0] wdata);
    logic ok;
    u_cfs_host_model.access(wr, code, wdata, rd_word, ok);
    check_flag(ok, 1'b1);
  endtask
  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    bus(1'b0, code, 16'h0000);
    check_word(rd_word, exp);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Bounded wait, so a stuck state is reported rather than hung on.
  task automatic wait_conv(input logic exp, input int lim);
    for (int i = 0; i < lim && converting !== exp; i++) ticks(1);
    check_flag(converting, exp);
  endtask
  task automatic sample_temp(input logic [15:0] t);
    temp = t;
    temp_valid = 1'b1;
    ticks(1);
    temp_valid = 1'b0;
    ticks(4);
  endtask
  task automatic rises(input int n);
    repeat (n) begin
      rise_tick = 1'b1;
      ticks(1);
      rise_tick = 1'b0;
      ticks(3);
    end
  endtask
  // Each on period opens the gate, then a peak trip must close it at once.
  task automatic pwm_peaks(input int n);
    repeat (n) begin
      pwm = 1'b1;
      ticks(6);
      check_flag(hs_gate, 1'b1);
      hs_peak = 1'b1;
      #1 check_flag(hs_gate, 1'b0);
      ticks(2);
      {pwm, hs_peak} = 2'b00;
      ticks(6);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ==========
  // Main sequence.
  initial begin
    {fail_count, samples_checked} = {32'sd0, 32'sd0};
    {sys_rst, supply_ok, ss_done, conv_en, pwm, rise_tick} = 6'h38;
    {hs_peak, ls_oc, bg_trip, fixed_ov, fault_rst, alert_mask} = 6'h00;
    {temp_valid, vout_valid} = 2'b00;
    {temp, vout, fb, fb_nom} = {16'h0030, 16'h0000, 16'h1000, 16'h1000};
    ticks(10);
    sys_rst = 1'b0;
    check_flag(alert_n, 1'b1);
    for (int i = 0; i < 8; i++) rd_chk(RCODE[i], RVAL[i]);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, RCODE[i], WVAL[i]);
      rd_chk(RCODE[i], WVAL[i] & 16'h00ff);
    end
    conv_en = 1'b1;
    wait_conv(1'b1, 50);
    sample_temp(16'h0050);
    bus(1'b1, 8'h8d, 16'habcd);
    rd_chk(8'h8d, 16'h0050);
    sample_temp(16'h0065);
    rd_chk(8'h7d, 16'h0040);
    check_flag(alert_n, 1'b0);
    alert_mask = 1'b1;
    ticks(3);
    check_flag(alert_n, 1'b1);
    alert_mask = 1'b0;
    sample_temp(16'h0078);
    rd_chk(8'h7d, 16'h00c0);
    check_flag(converting, 1'b1);
    bus(1'b1, 8'he0, 16'h002a);
    sample_temp(16'h0078);
    wait_conv(1'b0, 20);
    sample_temp(16'h006a);
    ticks(20);
    check_flag(converting, 1'b0);
    sample_temp(16'h0050);
    wait_conv(1'b1, 50);
    bus(1'b1, 8'he0, 16'h0028);
    bus(1'b1, 8'h7d, 16'h00c0);
    rd_chk(8'h7d, 16'h0000);
    check_flag(alert_n, 1'b1);
    bg_trip = 1'b1;
    wait_conv(1'b0, 10);
    rd_chk(8'he1, 16'h0001);
    bg_trip = 1'b0;
    wait_conv(1'b1, 50);
    bus(1'b1, 8'he1, 16'h001f);
    pwm_peaks(3);
    pwm = 1'b1;
    ticks(6);
    pwm = 1'b0;
    wait_conv(1'b0, 20);
    rd_chk(8'he1, 16'h0002);
    rises(6);
    check_flag(converting, 1'b0);
    rises(1);
    wait_conv(1'b1, 20);
    bus(1'b1, 8'he0, 16'h0000);
    pwm_peaks(4);
    check_flag(converting, 1'b1);
    // Ignored overvoltage, held too briefly to meet the checker's window.
    fixed_ov = 1'b1;
    ticks(3);
    check_flag(converting, 1'b1);
    fixed_ov = 1'b0;
    bus(1'b1, 8'he0, 16'h0028);
    bus(1'b1, 8'he1, 16'h001f);
    // Below the supply lockout the comparator must not count.
    {supply_ok, fixed_ov} = 2'b01;
    ticks(6);
    check_flag(converting, 1'b1);
    rd_chk(8'he1, 16'h0000);
    supply_ok = 1'b1;
    // Fixed comparator, programmed level (nominal + 1/16), then latch-off.
    for (int k = 0; k < 3; k++) begin
      if (k == 2) bus(1'b1, 8'he0, 16'h0018);
      if (k == 1) fb = 16'h1200;
      else fixed_ov = 1'b1;
      ticks(6);
      check_flag(ls_gate, 1'b1);
      rd_chk(8'he1, 16'h0004);
      {fixed_ov, fb} = {1'b0, 16'h1000};
      ticks(5);
      check_flag(converting, 1'b0);
      rises(7);
      if (k == 2) begin
        check_flag(converting, 1'b0);
        fault_rst = 1'b1;
        ticks(1);
        fault_rst = 1'b0;
      end
      wait_conv(1'b1, 20);
      bus(1'b1, 8'he1, 16'h001f);
    end
    vout = 16'h0400;
    repeat (64) begin
      vout_valid = 1'b1;
      ticks(1);
      vout_valid = 1'b0;
      ticks(1);
    end
    bus(1'b0, 8'h8b, 16'h0000);
    check_flag(rd_word >= 16'h03f8 && rd_word <= 16'h0400, 1'b1);
    bus(1'b1, 8'he0, 16'h00a8);
    fb = 16'h0e00;
    ticks(1000);
    check_flag(converting, 1'b1);
    // Past the start-up limit with undervoltage ignored, then restart.
    bus(1'b1, 8'he0, 16'h0028);
    ticks(40000);
    check_flag(converting, 1'b1);
    bus(1'b1, 8'he0, 16'h00a8);
    wait_conv(1'b0, 20);
    ticks(1);
    check_flag(ls_gate, 1'b0);
    check_flag(hs_gate, 1'b0);
    bus(1'b0, 8'he1, 16'h0000);
    check_flag(|(rd_word & 16'h0018), 1'b1);
    check_flag(alert_n, 1'b0);
    give_verdict();
  end
endmodule
